// file: rtl/wlb_pkg.sv
package wlb_pkg;

  // Clock and timing
  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_PERIOD_NS = 50;
  localparam int REP_HZ_HI = 183;
  localparam int REP_HZ_LO = 122;
  localparam int SLOTS = 256;
  localparam int MAX_ON_NS = 6000;

  // Slot length rounds down, so the rate lands slightly above nominal
  localparam int SLOT_CYC_HI = CLK_HZ / (REP_HZ_HI * SLOTS);
  localparam int SLOT_CYC_LO = CLK_HZ / (REP_HZ_LO * SLOTS);
  localparam int MAX_ON_CYC = MAX_ON_NS / CLK_PERIOD_NS;

  localparam int SLOT_W = 10;
  localparam int ON_W = 8;
  localparam int DUTY_W = 8;

  localparam logic [SLOT_W-1:0] SLOT_LEN_HI = SLOT_W'(SLOT_CYC_HI);
  localparam logic [SLOT_W-1:0] SLOT_LEN_LO = SLOT_W'(SLOT_CYC_LO);
  localparam logic [SLOT_W-1:0] SLOT_ZERO = 10'h000;
  localparam logic [SLOT_W-1:0] SLOT_ONE = 10'h001;
  localparam logic [ON_W-1:0] MAX_ON_LAST = ON_W'(MAX_ON_CYC - 1);
  localparam logic [ON_W-1:0] ON_ZERO = 8'h00;
  localparam logic [ON_W-1:0] ON_ONE = 8'h01;

  localparam logic [DUTY_W-1:0] DUTY_OFF = 8'h00;
  localparam logic [DUTY_W-1:0] DUTY_HALF = 8'h80;
  localparam logic [7:0] SLOT_IDX_ZERO = 8'h00;
  localparam logic [7:0] SLOT_IDX_ONE = 8'h01;

  // Soft-start step lasts 256 switching cycles
  localparam logic [7:0] SOFT_LAST = 8'hFF;
  localparam logic [7:0] SOFT_ZERO = 8'h00;
  localparam logic [7:0] SOFT_ONE = 8'h01;

  // Peak current limit select codes to the power stage
  localparam logic [1:0] LIM_125MA = 2'h0;
  localparam logic [1:0] LIM_250MA = 2'h1;
  localparam logic [1:0] LIM_500MA = 2'h2;

  typedef enum {
    WLB_OFF,
    WLB_SOFT_125,
    WLB_SOFT_250,
    WLB_RUN
  } wlb_stage_t;

  typedef struct packed {
    logic fb_below;
    logic peak_hit;
    logic fault;
  } wlb_sense_t;

  localparam int SENSE_W = $bits(wlb_sense_t);

endpackage

// file: rtl/wlb_sync.sv
`timescale 1ns/1ps
module wlb_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  wire [W-1:0] agree_mask = ~(s2 ^ s3);
  wire [W-1:0] next_q = (s2 & agree_mask) | (q & ~agree_mask);

  // Stage two and three must agree, so a single-cycle glitch is dropped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      q <= '0;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      q <= next_q;
    end
  end
endmodule

// file: rtl/wlb_boost_ctrl.sv
// How it works
// - Each repetition period holds 256 pulse slots, one duty step each.
// - At half-scale duty every slot is high for half its width.
// - Above half scale some slots are forced fully on, below it fully off.
// - On-time summed over one period equals the programmed duty fraction.
// - The rate select gives a 183 Hz period when high and 122 Hz when low.
// - The LED switch is held open during shutdown.
// - The duty register value alone sets LED switch duty, off from reset.
// - The power switch turns on only when feedback is low and LED is on.
// - The power switch turns off at the peak limit or after 6 us on-time.
// - The power switch turns off at once when the LED switch turns off.
// - Soft start steps the limit 125, 250, 500 mA, 256 cycles at 125 and at 250, then holds 500.
// - Duty zero means off mode; a nonzero duty starts via soft start.
// - Undervoltage or thermal fault forces off mode, both switches open.
`timescale 1ns/1ps
module wlb_boost_ctrl
  import wlb_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic [DUTY_W-1:0] LED_BOOST_DUTY_REG,
  input wire logic LED_REPETITION_RATE_SEL,
  input wire logic LED_CURRENT_SENSE_BELOW,
  input wire logic PEAK_CURRENT_REACHED,
  input wire logic SHUTDOWN_FAULT,
  output logic BACKLIGHT_PULSE_OUT,
  output logic POWER_SWITCH_ON,
  output logic [1:0] BOOST_PEAK_CURRENT_LIMIT
);

  function automatic logic [7:0] bit_reverse(input logic [7:0] v);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7-i];
    end
    return r;
  endfunction

  wlb_sense_t sense_raw;
  wlb_sense_t sense;
  wlb_stage_t stage;
  wlb_stage_t next_stage;
  logic [SLOT_W-1:0] slot_cyc;
  logic [7:0] slot_idx;
  logic [ON_W-1:0] on_cnt;
  logic [7:0] soft_cnt;

  assign sense_raw = '{fb_below: LED_CURRENT_SENSE_BELOW,
                       peak_hit: PEAK_CURRENT_REACHED,
                       fault: SHUTDOWN_FAULT};

  wlb_sync #(.W(SENSE_W)) u_sync (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .d(sense_raw),
    .q(sense)
  );

  // Slot timing
  wire [SLOT_W-1:0] slot_len = LED_REPETITION_RATE_SEL ?
                               SLOT_LEN_HI : SLOT_LEN_LO;
  wire [SLOT_W-1:0] half_len = slot_len >> 1;
  // Rate change mid-slot: >= lets a longer count end cleanly
  wire slot_end = slot_cyc >= (slot_len - SLOT_ONE);
  wire enabled = (stage != WLB_OFF);
  wire duty_zero = (LED_BOOST_DUTY_REG == DUTY_OFF);

  // Forced slots: k = 2*|N-128|, spread by bit reversal of slot index
  wire above_half = LED_BOOST_DUTY_REG > DUTY_HALF;
  wire [DUTY_W-1:0] duty_dist = above_half ?
                                (LED_BOOST_DUTY_REG - DUTY_HALF) :
                                (DUTY_HALF - LED_BOOST_DUTY_REG);
  wire [8:0] force_cnt = {duty_dist, 1'b0};
  wire slot_forced = {1'b0, bit_reverse(slot_idx)} < force_cnt;
  wire half_level = slot_cyc < half_len;
  wire slot_level = slot_forced ? above_half : half_level;
  wire next_led = enabled && !duty_zero && !sense.fault
                  && slot_level;

  // Power switch
  wire on_timeout = on_cnt >= MAX_ON_LAST;
  wire sw_turn_on = !POWER_SWITCH_ON && enabled && !sense.fault
                    && sense.fb_below && BACKLIGHT_PULSE_OUT
                    && next_led;
  wire sw_turn_off = POWER_SWITCH_ON && (sense.peak_hit || on_timeout
                     || !next_led);
  wire next_pwr = sw_turn_on || (POWER_SWITCH_ON && !sw_turn_off
                  && enabled);
  wire soft_step = sw_turn_off && (soft_cnt == SOFT_LAST);

  always_comb begin
    next_stage = stage;
    if (sense.fault || duty_zero) begin
      next_stage = WLB_OFF;
    end else begin
      case (stage)
        WLB_OFF: next_stage = WLB_SOFT_125;
        WLB_SOFT_125: begin
          if (soft_step) begin
            next_stage = WLB_SOFT_250;
          end
        end
        WLB_SOFT_250: begin
          if (soft_step) begin
            next_stage = WLB_RUN;
          end
        end
        WLB_RUN: next_stage = WLB_RUN;
        default: next_stage = WLB_OFF;
      endcase
    end
  end

  // Off mode parks at the lowest limit so a restart begins soft
  wire [1:0] next_limit = (next_stage == WLB_OFF) ? LIM_125MA :
                          (next_stage == WLB_SOFT_125) ? LIM_125MA :
                          (next_stage == WLB_SOFT_250) ? LIM_250MA :
                          LIM_500MA;
  wire [7:0] next_soft = (next_stage != stage) ? SOFT_ZERO :
                         (sw_turn_off ? soft_cnt + SOFT_ONE : soft_cnt);
  wire [SLOT_W-1:0] next_slot_cyc = (!enabled || slot_end) ?
                                    SLOT_ZERO : slot_cyc + SLOT_ONE;
  wire [7:0] next_slot_idx = !enabled ? SLOT_IDX_ZERO :
                             (slot_end ? slot_idx + SLOT_IDX_ONE : slot_idx);
  wire [ON_W-1:0] next_on = next_pwr ?
                            (POWER_SWITCH_ON ? on_cnt + ON_ONE : ON_ZERO) :
                            ON_ZERO;

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      stage <= WLB_OFF;
      soft_cnt <= SOFT_ZERO;
      BOOST_PEAK_CURRENT_LIMIT <= LIM_125MA;
    end else begin
      stage <= next_stage;
      soft_cnt <= next_soft;
      BOOST_PEAK_CURRENT_LIMIT <= next_limit;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      slot_cyc <= SLOT_ZERO;
      slot_idx <= SLOT_IDX_ZERO;
      BACKLIGHT_PULSE_OUT <= 1'b0;
    end else begin
      slot_cyc <= next_slot_cyc;
      slot_idx <= next_slot_idx;
      BACKLIGHT_PULSE_OUT <= next_led;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      on_cnt <= ON_ZERO;
      POWER_SWITCH_ON <= 1'b0;
    end else begin
      on_cnt <= next_on;
      POWER_SWITCH_ON <= next_pwr;
    end
  end

endmodule

// file: verif/wlb_stage_model.sv
`timescale 1ns/1ps
module wlb_stage_model (
  input wire logic clk,
  input wire logic pwr_on,
  input wire logic fb_low,
  input wire logic [7:0] peak_dly,
  output logic fb_below,
  output logic peak_hit
);
  logic [7:0] on_cyc = 8'h00;
  // Current builds only while on; delay 0 never reaches the limit
  always @(posedge clk) begin
    on_cyc <= pwr_on ? on_cyc + 8'h01 : 8'h00;
    peak_hit <= pwr_on && peak_dly != 8'h00 && on_cyc >= peak_dly;
  end
  assign fb_below = fb_low;
  initial peak_hit = 1'b0;
endmodule

// file: verif/wlb_chk_assertions.sv
`timescale 1ns/1ps
module wlb_chk
  import wlb_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic [DUTY_W-1:0] LED_BOOST_DUTY_REG,
  input wire logic PEAK_CURRENT_REACHED,
  input wire logic SHUTDOWN_FAULT,
  input wire logic BACKLIGHT_PULSE_OUT,
  input wire logic POWER_SWITCH_ON,
  input wire logic [1:0] BOOST_PEAK_CURRENT_LIMIT
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  logic [7:0] run;
  always_ff @(posedge REF_CLK or negedge RST_N)
    if (!RST_N) run <= 8'h00;
    else run <= POWER_SWITCH_ON ? run + 8'h01 : 8'h00;
  // Six samples: five edges through the three-flop synchroniser, agree stage and output flop, then the check
  sequence s_fault;
    SHUTDOWN_FAULT[*6];
  endsequence
  a_off_mode_idle: assert property (
    LED_BOOST_DUTY_REG == DUTY_OFF |=> !BACKLIGHT_PULSE_OUT &&
    !POWER_SWITCH_ON && BOOST_PEAK_CURRENT_LIMIT == LIM_125MA)
    else $error("off mode not idle");
  a_fault_opens: assert property (
    s_fault |-> !BACKLIGHT_PULSE_OUT && !POWER_SWITCH_ON)
    else $error("fault left a switch on");
  a_pwr_needs_led: assert property (
    POWER_SWITCH_ON |-> BACKLIGHT_PULSE_OUT) else $error("switch on, led off");
  a_pwr_start_led: assert property (
    $rose(POWER_SWITCH_ON) |-> $past(BACKLIGHT_PULSE_OUT))
    else $error("switch started with led off");
  a_peak_ends_on: assert property (
    $rose(PEAK_CURRENT_REACHED) |-> ##[1:5] !POWER_SWITCH_ON)
    else $error("peak did not end on-time");
  a_max_on_time: assert property (
    POWER_SWITCH_ON |-> run < 8'h78) else $error("on-time too long");
  a_limit_steps: assert property (
    $changed(BOOST_PEAK_CURRENT_LIMIT) && BOOST_PEAK_CURRENT_LIMIT != 2'h0
    |-> BOOST_PEAK_CURRENT_LIMIT == $past(BOOST_PEAK_CURRENT_LIMIT) + 2'h1)
    else $error("limit skipped a step");
  a_led_needs_duty: assert property (
    $rose(BACKLIGHT_PULSE_OUT) |-> $past(LED_BOOST_DUTY_REG) != DUTY_OFF)
    else $error("led on at zero duty");
endmodule
bind wlb_boost_ctrl wlb_chk i_chk (.*);

// file: verif/wlb_boost_ctrl_tb.sv
`timescale 1ns/1ps
module wlb_boost_ctrl_tb;
  import wlb_pkg::*;
  logic ref_clk = 1'b0, rst_n = 1'b0, rate = 1'b0, fault = 1'b0;
  logic fb_low = 1'b1, led, pwr, fb, peak;
  logic [7:0] duty = 8'h00, peak_dly = 8'h03;
  logic [1:0] lim;
  int n_mismatch = 0, n_compared = 0, falls = 0, run = 0, top = 0, hi, t;
  // Duty, rate, then half slots lit in slots 0 and 1
  logic [11:0] rows [8] = '{12'h80A, 12'h81B, 12'h7F9, 12'hC8C,
    12'h328, 12'hFF4, 12'h010, 12'h802};
  initial forever #25 ref_clk = ~ref_clk;
  wlb_boost_ctrl i_dut (.REF_CLK(ref_clk), .RST_N(rst_n),
    .LED_BOOST_DUTY_REG(duty), .LED_REPETITION_RATE_SEL(rate),
    .LED_CURRENT_SENSE_BELOW(fb), .PEAK_CURRENT_REACHED(peak),
    .SHUTDOWN_FAULT(fault), .BACKLIGHT_PULSE_OUT(led),
    .POWER_SWITCH_ON(pwr), .BOOST_PEAK_CURRENT_LIMIT(lim));
  wlb_stage_model i_stage (.clk(ref_clk), .pwr_on(pwr), .fb_low(fb_low),
    .peak_dly(peak_dly), .fb_below(fb), .peak_hit(peak));
  always @(posedge ref_clk) begin
    if (pwr !== 1'b1 && run > 0) falls++;
    run = (pwr === 1'b1) ? run + 1 : 0;
    if (run > top) top = run;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task close_out;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  initial begin
    cyc(2);
    chk({led, pwr, lim}, 32'h0);
    rst_n = 1'b1;
    foreach (rows[i]) begin
      duty = 8'h00;
      cyc(4);
      chk({led, pwr, lim}, 32'h0);
      {duty, rate} = rows[i][11:3];
      t = rate ? 213 : 320;
      hi = 0;
      repeat (4 * t + 1) begin
        @(negedge ref_clk);
        hi += led;
      end
      chk(hi, rows[i][2:0] * t);
    end
    duty = 8'h00;
    cyc(4);
    falls = 0;
    duty = 8'hFF;
    for (int s = 1; s < 3; s++) begin
      for (int k = 0; k < 20000 && lim !== 2'(s); k++) @(negedge ref_clk);
      @(posedge ref_clk);
      #1;
      chk(falls, 256 * s);
      if (lim !== 2'(s)) begin
        n_mismatch++;
        close_out;
      end
    end
    peak_dly = 8'h00;
    cyc(200);
    top = 0;
    cyc(1400);
    chk(top, 120);
    fb_low = 1'b0;
    cyc(130);
    top = 0;
    cyc(700);
    chk(top, 0);
    fault = 1'b1;
    cyc(5);
    chk({led, pwr, lim}, 32'h0);
    close_out;
  end
endmodule
